// *** design/arb_bus_if.sv ***
// Priority arbitration and address lines between the arbitrator and one device
`timescale 1ns/1ps
interface arb_bus_if;
  import arb_pkg::*;
  logic [NUM_LEVELS-1:0] req_drv;
  logic [NUM_LEVELS-1:0] req_line;
  logic [NUM_LEVELS-1:0] grant;
  logic [NUM_LEVELS-1:0] grant_pass;
  logic [NUM_LEVELS-1:0] chain_end;
  logic ack_drv;
  logic ack;
  logic busy_drv;
  logic busy;
  logic [ADDR_W-1:0] addr_drv;
  logic addr_oe;
  logic [ADDR_W-1:0] addr;

  // Wired-OR lines with a single device attached; the end of the chain is its pass output
  assign req_line = req_drv;
  assign chain_end = grant_pass;
  assign ack = ack_drv;
  assign busy = busy_drv;
  assign addr = addr_oe ? addr_drv : ADDR_ZERO;

  modport arbiter (
    input req_line,
    input chain_end,
    input ack,
    input busy,
    output grant
  );

  modport device (
    input grant,
    input busy,
    input addr,
    output req_drv,
    output grant_pass,
    output ack_drv,
    output busy_drv,
    output addr_drv,
    output addr_oe
  );
endinterface : arb_bus_if

// *** design/arb_pkg.sv ***
// Shared constants and state types for the grant chain arbiter and its devices
package arb_pkg;
  // ************************************************************
  // Bus shape
  // ************************************************************
  localparam int NUM_LEVELS = 5;
  localparam int NONPROC_IDX = 4;
  localparam int ADDR_W = 18;
  localparam int PLVL_W = 3;
  // Processor level codes 0..4; level request line i has rank i+1
  localparam logic [PLVL_W-1:0] PLVL_MAX = 3'h4;
  localparam logic [NUM_LEVELS-1:0] LEVELS_NONE = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;

  // ************************************************************
  // Arbitrator states
  // ************************************************************
  typedef enum logic [3:0] {
    ARB_IDLE = 4'h1,
    ARB_GRANT = 4'h2,
    ARB_ACKED = 4'h4,
    ARB_CANCEL = 4'h8
  } arb_state_t;

  // ************************************************************
  // Device controller states
  // ************************************************************
  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_REQ = 4'h2,
    DEV_WAIT = 4'h4,
    DEV_MASTER = 4'h8
  } dev_state_t;
endpackage : arb_pkg

// *** design/grant_chain_device.sv ***
// Requesting device controller on the daisy-chained grant lines
`timescale 1ns/1ps
module grant_chain_device
  import arb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  arb_bus_if.device bus,
  input wire logic [NUM_LEVELS-1:0] level_sel_i,
  input wire logic slave_only_i,
  input wire logic need_bus_i,
  input wire logic done_i,
  input wire logic [ADDR_W-1:0] xfer_addr_i,
  input wire logic [ADDR_W-1:0] own_addr_i,
  output logic master_o,
  output logic slave_sel_o
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NUM_LEVELS-1:0] gnt_s1_r;
  logic [NUM_LEVELS-1:0] gnt_s2_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic [ADDR_W-1:0] addr_s1_r;
  logic [ADDR_W-1:0] addr_s2_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      gnt_s1_r <= LEVELS_NONE;
      gnt_s2_r <= LEVELS_NONE;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      addr_s1_r <= ADDR_ZERO;
      addr_s2_r <= ADDR_ZERO;
    end
    else
    begin
      gnt_s1_r <= bus.grant; // [RULE20]
      gnt_s2_r <= gnt_s1_r;
      busy_s1_r <= bus.busy; // [RULE20]
      busy_s2_r <= busy_s1_r;
      addr_s1_r <= bus.addr;
      addr_s2_r <= addr_s1_r;
    end
  end

  // ************************************************************
  // Request, accept and mastership
  // ************************************************************
  dev_state_t state_r;
  dev_state_t state_nxt;
  logic [NUM_LEVELS-1:0] req_r;
  logic [NUM_LEVELS-1:0] pass_r;
  logic ack_r;
  logic busy_r;
  logic sel_r;
  logic [NUM_LEVELS-1:0] held_r;
  logic own_d1_r;
  logic own_d2_r;

  // Slave-only devices stay out of arbitration altogether
  wire [NUM_LEVELS-1:0] my_levels = slave_only_i ? LEVELS_NONE : level_sel_i; // [RULE14]
  wire [NUM_LEVELS-1:0] want = (state_r == DEV_REQ) ? my_levels : LEVELS_NONE;
  wire accept = ((gnt_s2_r & want) != LEVELS_NONE); // [RULE7]

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DEV_IDLE:
      begin
        if (need_bus_i && my_levels != LEVELS_NONE)
        begin
          state_nxt = DEV_REQ; // [RULE2]
        end
      end
      DEV_REQ:
      begin
        if (accept)
        begin
          state_nxt = DEV_WAIT; // [RULE7]
        end
      end
      DEV_WAIT:
      begin
        // Current master must release the data section first
        if (!busy_s2_r)
        begin
          state_nxt = DEV_MASTER; // [RULE6]
        end
      end
      DEV_MASTER:
      begin
        if (done_i)
        begin
          state_nxt = DEV_IDLE;
        end
      end
      default:
      begin
        state_nxt = DEV_IDLE;
      end
    endcase
  end

  // Pass is registered: adds latency per device but keeps outputs glitch free
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= DEV_IDLE;
      req_r <= LEVELS_NONE;
      pass_r <= LEVELS_NONE;
      ack_r <= 1'b0;
      busy_r <= 1'b0;
      sel_r <= 1'b0;
      held_r <= LEVELS_NONE;
      own_d1_r <= 1'b0;
      own_d2_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= (state_nxt == DEV_REQ) ? my_levels : LEVELS_NONE; // [RULE2] [RULE1]
      // Accepted grant stays blocked until it has drained from our sync stages
      held_r <= accept ? (gnt_s2_r & want) : (held_r & gnt_s2_r); // [RULE7]
      pass_r <= gnt_s2_r & ~want & ~held_r; // [RULE8] [RULE7] [RULE11]
      ack_r <= (state_nxt == DEV_WAIT); // [RULE7]
      busy_r <= (state_nxt == DEV_MASTER); // [RULE6]
      // Own busy delayed like the synced line, so our own tail never selects us
      own_d1_r <= busy_r;
      own_d2_r <= own_d1_r;
      sel_r <= busy_s2_r && !busy_r && !own_d2_r && (addr_s2_r == own_addr_i); // [RULE13]
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus.req_drv = req_r;
  assign bus.grant_pass = pass_r;
  assign bus.ack_drv = ack_r;
  assign bus.busy_drv = busy_r;
  assign bus.addr_drv = xfer_addr_i;
  assign bus.addr_oe = busy_r; // [RULE12]
  assign master_o = busy_r;
  assign slave_sel_o = sel_r;

endmodule : grant_chain_device

// *** design/priority_grant_chain_arbiter.sv ***
// Central arbitrator: picks the next master level and drives one grant line
// How it works
// [RULE1] Five request lines, one per level
// [RULE2] Needing device asserts request on its level
// [RULE3] Processor level tracked and compared with requests
// [RULE4] Nothing above processor level: no grant issued
// [RULE5] Grant highest active level above processor
// [RULE6] Granted device waits for bus release
// [RULE7] Requesting device acknowledges and blocks grant
// [RULE8] Idle device passes grant down chain
// [RULE9] Grant reaching bus end is cancelled, restarted
// [RULE10] Higher level always beats lower level
// [RULE11] Nearest device on chain wins within level
// [RULE12] Only master drives the address lines
// [RULE13] Slaves compare address, ignorant of master
// [RULE14] Slave-only devices never request nor accept
// [RULE15] Processor level arrives on separate input
// [RULE16] Nonprocessor grant issued whenever requested
// [RULE17] Lower grants need interrupt-ready and higher level
// [RULE18] Processor may master when top level quiet
// [RULE19] One grant outstanding until acknowledged or cancelled
// [RULE20] Asynchronous inputs synchronised before use
`timescale 1ns/1ps
module priority_grant_chain_arbiter
  import arb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  arb_bus_if.arbiter bus,
  input wire logic [PLVL_W-1:0] proc_level_i,
  input wire logic proc_int_ready_i,
  output logic [NUM_LEVELS-1:0] grant_o,
  output logic proc_may_master_o,
  output logic cancel_o
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NUM_LEVELS-1:0] req_s1_r;
  logic [NUM_LEVELS-1:0] req_s2_r;
  logic [NUM_LEVELS-1:0] end_s1_r;
  logic [NUM_LEVELS-1:0] end_s2_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic [PLVL_W-1:0] plvl_s1_r;
  logic [PLVL_W-1:0] plvl_s2_r;
  logic rdy_s1_r;
  logic rdy_s2_r;

  // Two flops per line; only the second stage feeds logic
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      req_s1_r <= LEVELS_NONE;
      req_s2_r <= LEVELS_NONE;
      end_s1_r <= LEVELS_NONE;
      end_s2_r <= LEVELS_NONE;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      plvl_s1_r <= 3'h0;
      plvl_s2_r <= 3'h0;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end
    else
    begin
      req_s1_r <= bus.req_line; // [RULE20] [RULE1]
      req_s2_r <= req_s1_r;
      end_s1_r <= bus.chain_end; // [RULE20]
      end_s2_r <= end_s1_r;
      ack_s1_r <= bus.ack; // [RULE20]
      ack_s2_r <= ack_s1_r;
      busy_s1_r <= bus.busy;
      busy_s2_r <= busy_s1_r;
      plvl_s1_r <= proc_level_i; // [RULE15]
      plvl_s2_r <= plvl_s1_r;
      rdy_s1_r <= proc_int_ready_i;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // ************************************************************
  // Eligibility and level choice
  // ************************************************************
  // Levels beyond the top code are clamped to PLVL_MAX, which still masks all four processor level lines
  wire [PLVL_W-1:0] plvl_eff = (plvl_s2_r > PLVL_MAX) ? PLVL_MAX : plvl_s2_r; // [RULE3]
  wire [NUM_LEVELS-1:0] eligible;
  wire [NUM_LEVELS-1:0] pick;

  // Nonprocessor level needs no processor consent
  assign eligible[NONPROC_IDX] = req_s2_r[NONPROC_IDX]; // [RULE16]

  // Level line i ranks i+1 and must exceed the processor level
  genvar gi;
  generate
    for (gi = 0; gi < NONPROC_IDX; gi++)
    begin : g_elig
      localparam logic [PLVL_W-1:0] RANK = PLVL_W'(gi + 1);
      assign eligible[gi] = req_s2_r[gi] && rdy_s2_r && (RANK > plvl_eff); // [RULE17] [RULE3]
    end
  endgenerate

  // Highest eligible line wins regardless of device positions
  assign pick[NONPROC_IDX] = eligible[NONPROC_IDX]; // [RULE10]
  generate
    for (gi = 0; gi < NONPROC_IDX; gi++)
    begin : g_pick
      assign pick[gi] = eligible[gi] && (eligible[NUM_LEVELS-1:gi+1] == '0); // [RULE10] [RULE5]
    end
  endgenerate

  wire any_pick = (pick != LEVELS_NONE); // [RULE4]

  // ************************************************************
  // Grant state machine
  // ************************************************************
  arb_state_t state_r;
  arb_state_t state_nxt;
  logic [NUM_LEVELS-1:0] grant_r;
  logic [NUM_LEVELS-1:0] grant_nxt;
  logic cancel_r;
  logic cancel_nxt;
  logic may_r;

  wire end_hit = ((end_s2_r & grant_r) != LEVELS_NONE);

  // One grant at a time; it stays until acknowledged or lost off the chain end
  always_comb
  begin
    state_nxt = state_r;
    grant_nxt = grant_r;
    cancel_nxt = 1'b0;
    case (state_r)
      ARB_IDLE:
      begin
        if (any_pick && !ack_s2_r)
        begin
          grant_nxt = pick; // [RULE5] [RULE19]
          state_nxt = ARB_GRANT;
        end
        else
        begin
          grant_nxt = LEVELS_NONE; // [RULE4]
        end
      end
      ARB_GRANT:
      begin
        if (ack_s2_r)
        begin
          grant_nxt = LEVELS_NONE; // [RULE19] [RULE7]
          state_nxt = ARB_ACKED;
        end
        else if (end_hit)
        begin
          grant_nxt = LEVELS_NONE; // [RULE9]
          cancel_nxt = 1'b1;
          state_nxt = ARB_CANCEL;
        end
      end
      ARB_ACKED:
      begin
        // New round only once the winner has let go of its acknowledge
        if (!ack_s2_r)
        begin
          state_nxt = ARB_IDLE;
        end
      end
      ARB_CANCEL:
      begin
        // Wait for the passed grant to drain from the chain, then restart
        if (end_s2_r == LEVELS_NONE)
        begin
          state_nxt = ARB_IDLE; // [RULE9]
        end
      end
      default:
      begin
        state_nxt = ARB_IDLE;
        grant_nxt = LEVELS_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ARB_IDLE;
      grant_r <= LEVELS_NONE;
      cancel_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
      cancel_r <= cancel_nxt;
    end
  end

  // ************************************************************
  // Processor mastership permission
  // ************************************************************
  // Top level quiet, no top-level grant out there and nobody holding the bus
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      may_r <= 1'b0;
    end
    else
    begin
      may_r <= !req_s2_r[NONPROC_IDX] && !grant_nxt[NONPROC_IDX] && !grant_r[NONPROC_IDX]
               && !busy_s2_r; // [RULE18]
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus.grant = grant_r; // [RULE11]
  assign grant_o = grant_r;
  assign cancel_o = cancel_r;
  assign proc_may_master_o = may_r;

endmodule : priority_grant_chain_arbiter

// *** sim/grant_chain_asserts.sv ***
// Concurrent checks on the grant chain bus between arbiter and device
`timescale 1ns/1ps
module grant_chain_asserts
  import arb_pkg::*;
(
  input logic clk_i,
  input logic sys_rst_i,
  input logic [NUM_LEVELS-1:0] req_line,
  input logic [NUM_LEVELS-1:0] grant,
  input logic [NUM_LEVELS-1:0] chain_end,
  input logic ack,
  input logic busy,
  input logic addr_oe
);
  // ************************************************************
  // Grant handshake checks
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Sync stages make every reaction three edges late
  one_grant_a: assert property ($onehot0(grant))
    else $error("more than one grant line high");
  grant_from_req_a: assert property ($rose(|grant) |-> |(grant & $past(req_line, 3)))
    else $error("grant without a request on its level");
  grant_holds_a: assert property ($fell(|grant) |-> $past(ack, 3) || (|$past(chain_end, 3)))
    else $error("grant dropped without ack or chain end");
  ack_ends_grant_a: assert property ($rose(ack) |-> ##[1:4] (grant == LEVELS_NONE))
    else $error("grant kept after ack");
  ack_needs_grant_a: assert property ($rose(ack) |-> |grant)
    else $error("ack without grant");
  no_regrant_a: assert property (ack |-> !$rose(|grant))
    else $error("new grant while ack high");
  ack_blocks_a: assert property ($rose(ack) |-> (chain_end == LEVELS_NONE) [*3])
    else $error("accepted grant passed on");
  req_kept_a: assert property ($fell(|req_line) |-> $rose(ack))
    else $error("request dropped before acceptance");
  master_waits_a: assert property ($rose(busy) |-> $fell(ack))
    else $error("mastership out of step with ack");
  addr_master_a: assert property (addr_oe |-> busy && (!$rose(addr_oe) || $past(ack)))
    else $error("address driven by non-master");
  // Main scenarios reached
  cover property ($rose(ack));
  cover property ($rose(busy));
  cover property ($fell(busy));
endmodule : grant_chain_asserts

// *** sim/priority_grant_chain_arbiter_tb.sv ***
// Self-checking bench: arbiter with a device, and an arbiter on a driven bus
`timescale 1ns/1ps
module priority_grant_chain_arbiter_tb;
  import arb_pkg::*;
  logic clk, rst, rdy, slv_only, need, done, pass_en;
  logic [PLVL_W-1:0] plvl;
  logic [NUM_LEVELS-1:0] lsel, grant1, grant2;
  logic [ADDR_W-1:0] xaddr;
  logic may1, may2, cancel2, master, ssel;
  int fails, checks_done, n;
  logic [NUM_LEVELS-1:0] t_req [6] = '{5'h0A, 5'h11, 5'h08, 5'h08, 5'h01, 5'h05};
  logic [PLVL_W-1:0] t_lvl [6] = '{3'h0, 3'h4, 3'h4, 3'h3, 3'h0, 3'h0};
  logic t_rdy [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  arb_bus_if bus1();
  arb_bus_if bus2();

  // ************************************************************
  // Instances
  // ************************************************************
  priority_grant_chain_arbiter priority_grant_chain_arbiter_i (
    .clk_i(clk), .sys_rst_i(rst), .bus(bus1), .proc_level_i(plvl),
    .proc_int_ready_i(rdy), .grant_o(grant1), .proc_may_master_o(may1), .cancel_o());
  grant_chain_device grant_chain_device_i (
    .clk_i(clk), .sys_rst_i(rst), .bus(bus1), .level_sel_i(lsel), .slave_only_i(slv_only),
    .need_bus_i(need), .done_i(done), .xfer_addr_i(xaddr), .own_addr_i(xaddr),
    .master_o(master), .slave_sel_o(ssel));
  grant_chain_asserts grant_chain_asserts_i (
    .clk_i(clk), .sys_rst_i(rst), .req_line(bus1.req_line), .grant(bus1.grant),
    .chain_end(bus1.chain_end), .ack(bus1.ack), .busy(bus1.busy), .addr_oe(bus1.addr_oe));
  // Second arbiter faces bench-driven lines so faults can be staged
  if (1)
  begin : fault_side
    priority_grant_chain_arbiter priority_grant_chain_arbiter_i (
      .clk_i(clk), .sys_rst_i(rst), .bus(bus2), .proc_level_i(plvl),
      .proc_int_ready_i(rdy), .grant_o(grant2), .proc_may_master_o(may2), .cancel_o(cancel2));
  end

  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Absent acceptor: grant passed straight to the chain end
  always @(posedge clk)
    bus2.grant_pass <= #2 pass_en ? bus2.grant : LEVELS_NONE;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge clk);
      #2;
    end
  endtask : tick

  task automatic chk(input string nm, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report();
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // Bounded waits count a miss and end the run
  task automatic tmo(input string nm);
    if (n >= 40)
    begin
      fails++;
      $display("CHECK FAILED %s expected done seen timeout", nm);
      final_report();
    end
  endtask : tmo

  task automatic wait_master(input logic v);
    for (n = 0; n < 40 && master !== v; n++)
      tick(1);
    tmo("master_o");
  endtask : wait_master

  task automatic finish_xfer();
    need = 1'b0;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    wait_master(1'b0);
    tick(1);
    chk("slave_sel_o", 1'b0, ssel);
  endtask : finish_xfer

  // Highest eligible level; nonprocessor level always eligible
  function automatic logic [NUM_LEVELS-1:0] exp_grant(input logic [NUM_LEVELS-1:0] r,
      input logic [PLVL_W-1:0] p, input logic ok);
    exp_grant = LEVELS_NONE;
    if (r[NONPROC_IDX])
      exp_grant = 5'h10;
    else
      for (int i = 0; i < NONPROC_IDX; i++)
        if (ok && r[i] && (i + 1 > p))
          exp_grant = 5'h01 << i;
  endfunction : exp_grant

  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    fails = 0;
    checks_done = 0;
    // Start slave-only, with the bench acting as the accepting device on bus2
    {rst, rdy, slv_only, need, done, pass_en} = 6'h38;
    {plvl, lsel, xaddr} = {3'h0, 5'h10, 18'h2A5C3};
    {bus2.req_drv, bus2.ack_drv, bus2.busy_drv, bus2.addr_drv, bus2.addr_oe} = '0;
    tick(8);
    rst = 1'b0;
    // Slave-only end stays silent
    need = 1'b1;
    tick(10);
    chk("req_line", LEVELS_NONE, bus1.req_line);
    chk("master_o", 1'b0, master);
    // Nonprocessor transfer to mastership
    slv_only = 1'b0;
    wait_master(1'b1);
    chk("addr", xaddr, bus1.addr);
    chk("slave_sel_o", 1'b0, ssel);
    tick(4);
    chk("may_master", 1'b0, may1);
    chk("grant_o", LEVELS_NONE, grant1);
    finish_xfer();
    tick(4);
    chk("may_master", 1'b1, may1);
    // Level grant held back until processor level drops
    lsel = 5'h02;
    plvl = 3'h2;
    need = 1'b1;
    tick(12);
    chk("req_line", 5'h02, bus1.req_line);
    chk("grant_o", LEVELS_NONE, grant1);
    plvl = 3'h1;
    wait_master(1'b1);
    finish_xfer();
    // Level table on the driven bus; bench acks as accepting device
    for (int k = 0; k < 6; k++)
    begin
      {plvl, rdy, bus2.req_drv} = {t_lvl[k], t_rdy[k], t_req[k]};
      for (n = 0; n < 8 && grant2 === LEVELS_NONE; n++)
        tick(1);
      chk("grant2", exp_grant(t_req[k], t_lvl[k], t_rdy[k]), grant2);
      chk("may_master2", !t_req[k][NONPROC_IDX], may2);
      bus2.ack_drv = |grant2;
      for (n = 0; n < 40 && grant2 !== LEVELS_NONE; n++)
        tick(1);
      tmo("ack2");
      {bus2.ack_drv, bus2.req_drv} = '0;
      tick(6);
    end
    // Nobody accepts: cancel, then arbitration restarts
    {plvl, rdy, pass_en, bus2.req_drv} = {3'h0, 1'b1, 1'b1, 5'h04};
    for (n = 0; n < 40 && cancel2 !== 1'b1; n++)
      tick(1);
    tmo("cancel_o");
    chk("grant2", LEVELS_NONE, grant2);
    tick(1);
    chk("cancel_o", 1'b0, cancel2);
    for (n = 0; n < 40 && grant2 !== 5'h04; n++)
      tick(1);
    tmo("regrant");
    {pass_en, bus2.ack_drv} = 2'h1;
    for (n = 0; n < 40 && grant2 !== LEVELS_NONE; n++)
      tick(1);
    tmo("ack2");
    final_report();
  end
endmodule : priority_grant_chain_arbiter_tb
